// *** ocg_global_regs.sv ***
// Global mask, receive status, FIFO sizing and two-wire control registers
`timescale 1ns/1ps
module ocg_global_regs
  import ocg_pkg::*;
#(
  parameter bit DYNAMIC_FIFO_SIZING = 1'b1,
  parameter bit DEDICATED_TX_FIFO = 1'b0,
  parameter bit HIBERNATION = 1'b0,
  parameter bit ISO_OUT_SUPPORT = 1'b1,
  parameter logic [15:0] LARGEST_RX_FIFO_DEPTH = RX_DEPTH_RESET,
  parameter logic [15:0] LARGEST_NP_TX_FIFO_DEPTH = NP_DEPTH_RESET,
  parameter int RX_QUEUE_DEPTH = 4
)
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  output logic [31:0] REG_RDATA,
  input wire logic CURRENT_ROLE_IN,
  output logic CURRENT_ROLE,
  input wire logic [31:0] INT_STATUS,
  output logic GLOBAL_IRQ,
  input wire logic RXS_PUSH,
  input wire logic [3:0] RXS_FRAME_LOW_BITS,
  input wire logic [3:0] RXS_PACKET_STATUS_CODE,
  input wire logic [1:0] RXS_DATA_PID_CODE,
  input wire logic [10:0] RXS_RECEIVED_BYTE_COUNT,
  input wire logic [3:0] RXS_CHANNEL_OR_ENDPOINT_INDEX,
  output logic RXS_READY,
  output logic RXS_NONEMPTY,
  output logic RXS_HEAD_EVENT,
  input wire logic [6:0] NP_REQUEST_QUEUE_HEAD,
  input wire logic [7:0] NP_REQUEST_QUEUE_FREE,
  input wire logic [15:0] NP_TX_FIFO_FREE_WORDS,
  output logic [15:0] RX_FIFO_DEPTH,
  output logic [15:0] NP_TX_FIFO_DEPTH,
  output logic [15:0] NP_TX_FIFO_START,
  output logic NP_TX_FIFO_IN_USE,
  output logic TWO_WIRE_REQ,
  output logic TWO_WIRE_READ,
  output logic TWO_WIRE_MASTER_ENABLE,
  output logic [22:0] TWO_WIRE_WORD,
  input wire logic TWO_WIRE_DONE,
  input wire logic TWO_WIRE_ACK,
  input wire logic [7:0] TWO_WIRE_RDATA
);
  // Register state
  logic [31:0] mask_q, mask_d;
  logic [15:0] rx_depth_q, rx_depth_d;
  logic [15:0] np_depth_q, np_depth_d;
  logic [15:0] np_start_q, np_start_d;
  logic tw_read_q, tw_read_d;
  logic tw_enable_q, tw_enable_d;
  logic [22:0] tw_word_q, tw_word_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic role_q, role_d;
  logic head_event_q, head_event_d;
  logic in_use_q, in_use_d;
  // Decode and helpers
  logic wr_mask, wr_rx_fsize, wr_np_fsize, wr_tw;
  logic rd_pop;
  logic [31:0] mask_eff;
  logic [RXS_WIDTH-1:0] rxs_entry, rxs_head;
  logic [3:0] frame_bits, head_code;
  logic rxs_ready, rxs_valid;
  logic tw_start;
  logic tw_busy, tw_req, tw_ack, tw_done;
  logic [7:0] npq_free_sat;
  logic [15:0] npf_free_sat;
  logic [31:0] fifo_word, np_status_word, tw_ctl_word, rxs_word;

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  assign wr_mask = REG_WR && (REG_ADDR == OFS_INT_MASK);
  assign wr_rx_fsize = REG_WR && (REG_ADDR == OFS_RX_FSIZE);
  assign wr_np_fsize = REG_WR && (REG_ADDR == OFS_NP_FSIZE);
  assign wr_tw = REG_WR && (REG_ADDR == OFS_TWO_WIRE);
  assign rd_pop = REG_RD && (REG_ADDR == OFS_RX_POP);

  ////////////////////////////////////////////////////////////////////////
  // Receive status entry packing; frame bits only where they mean something
  // device iso only
  assign frame_bits = (ISO_OUT_SUPPORT && !CURRENT_ROLE_IN) ? RXS_FRAME_LOW_BITS : 4'h0;
  assign rxs_entry = {frame_bits, RXS_PACKET_STATUS_CODE, RXS_DATA_PID_CODE,
                      RXS_RECEIVED_BYTE_COUNT, RXS_CHANNEL_OR_ENDPOINT_INDEX};

  ocg_rx_status_queue #(
    .WIDTH(RXS_WIDTH),
    .DEPTH(RX_QUEUE_DEPTH)
  ) u_rx_queue (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .clk_en(CLK_EN),
    .push(RXS_PUSH),
    .push_data(rxs_entry),
    .pop(rd_pop),
    .ready(rxs_ready),
    .valid(rxs_valid),
    .head(rxs_head)
  );

  assign head_code = rxs_head[RXS_CODE_LSB +: 4];
  assign rxs_word = {{(32 - RXS_WIDTH){1'b0}}, rxs_head};

  ////////////////////////////////////////////////////////////////////////
  // Two-wire sequencer; a start is ignored while busy
  assign tw_start = wr_tw && REG_WDATA[TW_BUSY_BIT] && !tw_busy;

  ocg_two_wire_seq u_two_wire (
    .clk(CORE_CLK),
    .rst_n(RESET_N),
    .clk_en(CLK_EN),
    .start(tw_start),
    .master_enable(tw_enable_q),
    .link_done(TWO_WIRE_DONE),
    .link_ack(TWO_WIRE_ACK),
    .busy_q(tw_busy),
    .req_q(tw_req),
    .ack_q(tw_ack),
    .done_q(tw_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupt mask gating
  always_comb
  begin
    mask_eff = mask_q;
    if (!HIBERNATION)
      mask_eff[MASK_RESTORE_BIT] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Status words seen by reads; free counts saturate at their maxima
  // queue free
  assign npq_free_sat = (NP_REQUEST_QUEUE_FREE > NPQ_FREE_MAX) ? NPQ_FREE_MAX : NP_REQUEST_QUEUE_FREE;
  assign npf_free_sat = (NP_TX_FIFO_FREE_WORDS > NPF_FREE_MAX) ? NPF_FREE_MAX : NP_TX_FIFO_FREE_WORDS;
  assign np_status_word = {1'b0, NP_REQUEST_QUEUE_HEAD, npq_free_sat, npf_free_sat};
  assign fifo_word = {np_depth_q, np_start_q};
  assign tw_ctl_word = {tw_busy, tw_read_q, 5'h00, tw_ack, tw_enable_q, tw_word_q} |
                       {8'h00, 1'b0, 23'h00_0000};

  ////////////////////////////////////////////////////////////////////////
  // Next register values
  always_comb
  begin
    mask_d = mask_q;
    rx_depth_d = rx_depth_q;
    np_depth_d = np_depth_q;
    np_start_d = np_start_q;
    tw_read_d = tw_read_q;
    tw_enable_d = tw_enable_q;
    tw_word_d = tw_word_q;
    rdata_d = rdata_q;
    if (wr_mask)
      mask_d = REG_WDATA & MASK_WRITABLE;
    if (DYNAMIC_FIFO_SIZING && wr_rx_fsize)
      rx_depth_d = REG_WDATA[15:0];
    if (DYNAMIC_FIFO_SIZING && wr_np_fsize)
    begin
      np_depth_d = REG_WDATA[FSIZE_DEPTH_LSB +: 16];
      np_start_d = REG_WDATA[15:0];
    end
    // Fields other than enable are frozen while a transfer runs, so the link sees stable values
    if (wr_tw && !tw_busy)
    begin
      tw_read_d = REG_WDATA[TW_READ_BIT];
      tw_enable_d = REG_WDATA[TW_ENABLE_BIT];
      tw_word_d = REG_WDATA[22:0];
    end
    else if (wr_tw)
      tw_enable_d = REG_WDATA[TW_ENABLE_BIT];
    // Read data lands in the low byte when a read finishes
    if (tw_done && tw_read_q)
      tw_word_d[7:0] = TWO_WIRE_RDATA;
    if (REG_RD)
    begin
      unique case (REG_ADDR)
        OFS_INT_MASK: rdata_d = mask_q;
        OFS_RX_PEEK, OFS_RX_POP: rdata_d = rxs_word;
        OFS_RX_FSIZE: rdata_d = {16'h0000, rx_depth_q};
        OFS_NP_FSIZE: rdata_d = fifo_word;
        OFS_NP_STATUS: rdata_d = np_status_word;
        OFS_TWO_WIRE: rdata_d = tw_ctl_word;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Derived outputs
  always_comb
  begin
    irq_d = |(INT_STATUS & mask_eff);
    role_d = CURRENT_ROLE_IN;
    in_use_d = CURRENT_ROLE_IN || !DEDICATED_TX_FIFO;
    head_event_d = 1'b0;
    if (rxs_valid)
    begin
      if (CURRENT_ROLE_IN)
        head_event_d = (head_code == PKT_TRANSFER_DONE) || (head_code == PKT_TOGGLE_ERROR) ||
                       (head_code == PKT_CHANNEL_HALTED);
      else
        head_event_d = (head_code == PKT_GLOBAL_OUT_NAK) || (head_code == PKT_TRANSFER_DONE) ||
                       (head_code == PKT_SETUP_DONE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register stage; CLK_EN low holds everything
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      mask_q <= MASK_RESET;
      rx_depth_q <= LARGEST_RX_FIFO_DEPTH;
      np_depth_q <= LARGEST_NP_TX_FIFO_DEPTH;
      np_start_q <= LARGEST_RX_FIFO_DEPTH;
      tw_read_q <= 1'b0;
      tw_enable_q <= 1'b0;
      tw_word_q <= TW_WORD_RESET;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      role_q <= 1'b0;
      head_event_q <= 1'b0;
      in_use_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      mask_q <= mask_d;
      rx_depth_q <= rx_depth_d;
      np_depth_q <= np_depth_d;
      np_start_q <= np_start_d;
      tw_read_q <= tw_read_d;
      tw_enable_q <= tw_enable_d;
      tw_word_q <= tw_word_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      role_q <= role_d;
      head_event_q <= head_event_d;
      in_use_q <= in_use_d;
    end
  end

  // Queue flags are count compares, delayed one cycle to come from flops
  logic rxs_ready_q, rxs_nonempty_q;
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rxs_ready_q <= 1'b0;
      rxs_nonempty_q <= 1'b0;
    end
    else if (CLK_EN)
    begin
      rxs_ready_q <= rxs_ready;
      rxs_nonempty_q <= rxs_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output assignments, all from flops
  assign REG_RDATA = rdata_q;
  assign CURRENT_ROLE = role_q;
  assign GLOBAL_IRQ = irq_q;
  assign RXS_READY = rxs_ready_q;
  assign RXS_NONEMPTY = rxs_nonempty_q;
  assign RXS_HEAD_EVENT = head_event_q;
  assign RX_FIFO_DEPTH = rx_depth_q;
  assign NP_TX_FIFO_DEPTH = np_depth_q;
  assign NP_TX_FIFO_START = np_start_q;
  assign NP_TX_FIFO_IN_USE = in_use_q;
  assign TWO_WIRE_REQ = tw_req;
  assign TWO_WIRE_READ = tw_read_q;
  assign TWO_WIRE_MASTER_ENABLE = tw_enable_q;
  assign TWO_WIRE_WORD = tw_word_q;
endmodule : ocg_global_regs

// *** ocg_global_regs_checker.sv ***
// Assertion checker for the global register block
`timescale 1ns/1ps
module ocg_global_regs_checker
  import ocg_pkg::*;
#(
  parameter bit HIBERNATION = 1'b0,
  parameter bit DYNAMIC_FIFO_SIZING = 1'b1
)
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic CLK_EN,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_WDATA,
  input wire logic [31:0] REG_RDATA,
  input wire logic CURRENT_ROLE_IN,
  input wire logic CURRENT_ROLE,
  input wire logic [31:0] INT_STATUS,
  input wire logic GLOBAL_IRQ,
  input wire logic [15:0] RX_FIFO_DEPTH,
  input wire logic [15:0] NP_TX_FIFO_START,
  input wire logic TWO_WIRE_REQ,
  input wire logic TWO_WIRE_DONE
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // Restore mask bit has no effect without hibernation
  localparam logic [31:0] EFF = HIBERNATION ? 32'hffff_ffff : 32'hfffe_ffff;
  logic [31:0] msk_q, msk_d;
  logic bsy_q, bsy_d, en_q, en_d, wr_en;
  logic [15:0] wd_lo;
  assign wr_en = CLK_EN && REG_WR;
  assign wd_lo = REG_WDATA[15:0];
  ////////////////////////////////////////////////////////////////
  // Shadow of mask, enable and busy, tracked from the register port and link done
  always_comb
  begin
    msk_d = msk_q;
    bsy_d = bsy_q;
    en_d = en_q;
    // Enable follows every control write, busy or not
    if (wr_en && REG_ADDR == OFS_TWO_WIRE)
      en_d = REG_WDATA[TW_ENABLE_BIT];
    if (wr_en && REG_ADDR == OFS_INT_MASK)
      msk_d = REG_WDATA & MASK_WRITABLE;
    if (wr_en && REG_ADDR == OFS_TWO_WIRE && REG_WDATA[31])
      bsy_d = 1'b1;
    if (CLK_EN && TWO_WIRE_DONE)
      bsy_d = 1'b0;
  end
  // Registers only
  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      msk_q <= MASK_RESET;
      bsy_q <= 1'b0;
      en_q <= 1'b0;
    end
    else
    begin
      msk_q <= msk_d;
      bsy_q <= bsy_d;
      en_q <= en_d;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Start write with the master already enabled and no transfer pending
  sequence tw_start;
    wr_en && REG_ADDR == OFS_TWO_WIRE && REG_WDATA[31] && en_q && !bsy_q;
  endsequence
  chk_mask_read_back: assert property (CLK_EN && REG_RD && REG_ADDR == OFS_INT_MASK |=> REG_RDATA == $past(msk_q))
    else $error("mask read differs from written value");
  chk_irq_mask_and: assert property (CLK_EN |=> GLOBAL_IRQ == |($past(INT_STATUS) & $past(msk_q) & EFF))
    else $error("interrupt output wrong for status and mask");
  chk_rdata_holds: assert property (!(CLK_EN && REG_RD) |=> $stable(REG_RDATA))
    else $error("read data changed without a read");
  chk_rx_depth_wr: assert property (wr_en && REG_ADDR == OFS_RX_FSIZE |=>
    RX_FIFO_DEPTH == (DYNAMIC_FIFO_SIZING ? $past(wd_lo) : $past(RX_FIFO_DEPTH)))
    else $error("rx depth not updated by write");
  chk_np_start_wr: assert property (wr_en && REG_ADDR == OFS_NP_FSIZE |=>
    NP_TX_FIFO_START == (DYNAMIC_FIFO_SIZING ? $past(wd_lo) : $past(NP_TX_FIFO_START)))
    else $error("np start not updated by write");
  chk_role_copy: assert property (CLK_EN |=> CURRENT_ROLE == $past(CURRENT_ROLE_IN))
    else $error("role output does not follow core role");
  chk_req_one_cycle: assert property (TWO_WIRE_REQ && CLK_EN |=> !TWO_WIRE_REQ)
    else $error("link request longer than one cycle");
  chk_start_to_req: assert property (tw_start ##1 CLK_EN |=> TWO_WIRE_REQ)
    else $error("link request missing after start");
  chk_req_only_busy: assert property (TWO_WIRE_REQ |-> bsy_q)
    else $error("link request while not busy");
endmodule : ocg_global_regs_checker

bind ocg_global_regs ocg_global_regs_checker #(.HIBERNATION(HIBERNATION), .DYNAMIC_FIFO_SIZING(DYNAMIC_FIFO_SIZING))
  u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
  .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .CURRENT_ROLE_IN(CURRENT_ROLE_IN),
  .CURRENT_ROLE(CURRENT_ROLE), .INT_STATUS(INT_STATUS), .GLOBAL_IRQ(GLOBAL_IRQ), .RX_FIFO_DEPTH(RX_FIFO_DEPTH),
  .NP_TX_FIFO_START(NP_TX_FIFO_START), .TWO_WIRE_REQ(TWO_WIRE_REQ), .TWO_WIRE_DONE(TWO_WIRE_DONE));

// *** ocg_global_regs_test.sv ***
// Self-checking testbench for the global register block
`timescale 1ns/1ps
module ocg_global_regs_test
  import ocg_pkg::*;
;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, role_in = 1'b0, push = 1'b0, ce = 1'b1;
  logic tw_done = 1'b0, tw_ack = 1'b0, tw_ack_m = 1'b1;
  logic [7:0] addr = 8'h00, tw_rdata = 8'h00, q_free = 8'h00;
  logic [31:0] wdata = 32'h0, status = 32'h0, lfsr_q = 32'habca, r, rdata, model_mask;
  logic [3:0] fr = 4'h0, code = 4'h0, idx = 4'h0;
  logic [1:0] pid = 2'h0;
  logic [10:0] received_byte_count = 11'h0;
  logic [6:0] q_head = 7'h0;
  logic [15:0] f_words = 16'h0, rx_depth, np_depth, np_start;
  logic role, irq, rxs_ne, rxs_rdy, head_ev, in_use, tw_req, tw_read, tw_en, ev, d;
  logic [22:0] tw_word, w;
  logic [23:0] req_cap = 24'h0;
  logic [3:0] codes [9] = '{4'h2, 4'h3, 4'h5, 4'h7, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
  logic [31:0] rxq [$];
  int err_count = 0, n_checks = 0, n_req = 0;
  always #2 clk = ~clk;
  ocg_global_regs dut (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(ce), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .CURRENT_ROLE_IN(role_in), .CURRENT_ROLE(role), .INT_STATUS(status),
    .GLOBAL_IRQ(irq), .RXS_PUSH(push), .RXS_FRAME_LOW_BITS(fr), .RXS_PACKET_STATUS_CODE(code),
    .RXS_DATA_PID_CODE(pid), .RXS_RECEIVED_BYTE_COUNT(received_byte_count), .RXS_CHANNEL_OR_ENDPOINT_INDEX(idx), .RXS_READY(rxs_rdy),
    .RXS_NONEMPTY(rxs_ne), .RXS_HEAD_EVENT(head_ev), .NP_REQUEST_QUEUE_HEAD(q_head), .NP_REQUEST_QUEUE_FREE(q_free),
    .NP_TX_FIFO_FREE_WORDS(f_words), .RX_FIFO_DEPTH(rx_depth), .NP_TX_FIFO_DEPTH(np_depth),
    .NP_TX_FIFO_START(np_start), .NP_TX_FIFO_IN_USE(in_use), .TWO_WIRE_REQ(tw_req), .TWO_WIRE_READ(tw_read),
    .TWO_WIRE_MASTER_ENABLE(tw_en), .TWO_WIRE_WORD(tw_word), .TWO_WIRE_DONE(tw_done), .TWO_WIRE_ACK(tw_ack),
    .TWO_WIRE_RDATA(tw_rdata));
  ////////////////////////////////////////////////////////////////
  // Fixed-seed shift register for field values
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // Bus tasks start at a falling edge and leave one idle cycle
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] dt);
    addr = a;
    wdata = dt;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    check(rdata, exp);
    @(negedge clk);
  endtask : reg_rd
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  // Capture every link request; the pulse is too short to poll
  always @(posedge clk)
  begin
    if (tw_req === 1'b1)
    begin
      n_req <= n_req + 1;
      req_cap <= {tw_read, tw_word};
    end
  end
  // Cut a hang short
  initial
  begin
    #100000;
    err_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    reg_rd(OFS_INT_MASK, MASK_RESET);
    reg_rd(OFS_RX_FSIZE, {16'h0, RX_DEPTH_RESET});
    reg_rd(OFS_NP_FSIZE, {NP_DEPTH_RESET, RX_DEPTH_RESET});
    reg_rd(OFS_TWO_WIRE, 32'h0100_0000);
    reg_rd(8'h34, 32'h0);
    // one source at a time, restore bit always masked in
    for (int b = 1; b < 32; b++)
    begin
      r = rnd() | 32'h0001_0000;
      model_mask = r & MASK_WRITABLE;
      reg_wr(OFS_INT_MASK, r);
      reg_rd(OFS_INT_MASK, model_mask);
      status = 32'h1 << b;
      repeat (2) @(negedge clk);
      check({31'h0, irq}, {31'h0, model_mask[b] && b != MASK_RESTORE_BIT});
    end
    status = 32'h0;
    // Clock enable low freezes state, so this write must not land
    ce = 1'b0;
    reg_wr(OFS_INT_MASK, 32'hffff_fffe);
    ce = 1'b1;
    reg_rd(OFS_INT_MASK, model_mask);
    // every code of both roles, peek then pop then empty pop
    for (int i = 0; i < 9; i++)
    begin
      role_in = (i < 4);
      repeat (2) @(negedge clk);
      r = rnd();
      {fr, pid, received_byte_count, idx} = r[20:0];
      code = codes[i];
      ev = role_in ? (code inside {4'h3, 4'h5, 4'h7}) : (code inside {4'h1, 4'h3, 4'h4});
      rxq.push_back({7'h0, role_in ? 4'h0 : fr, code, pid, received_byte_count, idx});
      push = 1'b1;
      @(negedge clk);
      push = 1'b0;
      repeat (2) @(negedge clk);
      check({28'h0, role, in_use, rxs_ne, head_ev}, {28'h0, role_in, 1'b1, 1'b1, ev});
      reg_rd(OFS_RX_PEEK, rxq[0]);
      reg_rd(OFS_RX_POP, rxq.pop_front());
      reg_rd(OFS_RX_POP, 32'h0);
    end
    // Four pushes fill the queue; a fifth is dropped and ready falls
    for (int i = 0; i < 5; i++)
    begin
      code = codes[i + 4];
      if (i < 4)
        rxq.push_back({7'h0, fr, code, pid, received_byte_count, idx});
      push = 1'b1;
      @(negedge clk);
    end
    push = 1'b0;
    @(negedge clk);
    check({31'h0, rxs_rdy}, 32'h0);
    while (rxq.size() > 0)
      reg_rd(OFS_RX_POP, rxq.pop_front());
    check({31'h0, rxs_rdy}, 32'h1);
    // sizes stay within the power-on values
    r = rnd();
    reg_wr(OFS_RX_FSIZE, {16'hffff, 6'h0, r[9:0]});
    reg_wr(OFS_NP_FSIZE, {8'h0, r[23:16], 6'h0, r[9:0]});
    reg_rd(OFS_RX_FSIZE, {22'h0, r[9:0]});
    reg_rd(OFS_NP_FSIZE, {8'h0, r[23:16], 6'h0, r[9:0]});
    check({rx_depth, np_depth}, {6'h0, r[9:0], 8'h0, r[23:16]});
    check({16'h0, np_start}, {22'h0, r[9:0]});
    for (int k = 0; k < 2; k++)
    begin
      r = rnd();
      q_head = r[6:0];
      q_free = k ? NPQ_FREE_MAX : {5'h0, r[10:8]};
      f_words = k ? NPF_FREE_MAX : {1'b0, r[30:16]};
      reg_rd(OFS_NP_STATUS, {1'b0, q_head, q_free, f_words});
    end
    // enable the master before any request
    reg_wr(OFS_TWO_WIRE, 32'h0080_0000);
    for (int k = 0; k < 2; k++)
    begin
      r = rnd();
      d = (k == 0);
      w = r[22:0];
      reg_wr(OFS_TWO_WIRE, {1'b1, d, 6'h0, 1'b1, w});
      repeat (2) @(negedge clk);
      check({n_req[6:0], req_cap, tw_en}, {7'(k + 1), d, w, 1'b1});
      reg_rd(OFS_TWO_WIRE, {1'b1, d, 5'h0, tw_ack_m, 1'b1, w});
      // Second start while busy must leave everything but enable alone
      reg_wr(OFS_TWO_WIRE, {1'b1, ~d, 6'h0, 1'b1, ~w});
      reg_rd(OFS_TWO_WIRE, {1'b1, d, 5'h0, tw_ack_m, 1'b1, w});
      tw_ack = d;
      tw_rdata = r[31:24];
      tw_done = 1'b1;
      @(negedge clk);
      tw_done = 1'b0;
      tw_ack_m = d;
      @(negedge clk);
      reg_rd(OFS_TWO_WIRE, {1'b0, d, 5'h0, tw_ack_m, 1'b1, w[22:8], d ? r[31:24] : w[7:0]});
      check(n_req, k + 1);
    end
    close_out();
  end
endmodule : ocg_global_regs_test

// *** ocg_pkg.sv ***
// Constants and types shared by the global register block
// Overview of operation
// - Mask register at 0x18, bit 0 zero
// - Mask bit 21 meaning follows role
// - Restore mask active only with hibernation
// - Status peek at 0x1c, pop at 0x20
// - Frame low bits 24:21, device iso
// - Host packet codes 2,3,5,7
// - Device packet codes 1,2,3,4,6
// - Data PID code in bits 16:15
// - Byte count in bits 14:4
// - Channel or endpoint in bits 3:0
// - Rx depth in words, reset largest
// - Sizes writable only with dynamic sizing
// - Np tx depth used per role/option
// - Np tx start resets after rx FIFO
// - Request queue head in bits 30:24
// - Request queue free in bits 23:16
// - Np tx FIFO free words bits 15:0
// - Busy bit set starts, hardware clears
// - Bit 30 selects read or write
// - Read-only role bit, 1 is host
package ocg_pkg;
  localparam logic [7:0] OFS_INT_MASK = 8'h18;
  localparam logic [7:0] OFS_RX_PEEK = 8'h1c;
  localparam logic [7:0] OFS_RX_POP = 8'h20;
  localparam logic [7:0] OFS_RX_FSIZE = 8'h24;
  localparam logic [7:0] OFS_NP_FSIZE = 8'h28;
  localparam logic [7:0] OFS_NP_STATUS = 8'h2c;
  localparam logic [7:0] OFS_TWO_WIRE = 8'h30;
  // Mask fields
  localparam int MASK_INCOMPLETE_BIT = 21;
  localparam int MASK_RESTORE_BIT = 16;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_WRITABLE = 32'hffff_fffe;
  // Receive status entry fields
  localparam int RXS_WIDTH = 25;
  localparam int RXS_FRAME_LSB = 21;
  localparam int RXS_CODE_LSB = 17;
  localparam int RXS_PID_LSB = 15;
  localparam int RXS_RECEIVED_BYTE_COUNT_LSB = 4;
  localparam int RXS_INDEX_LSB = 0;
  // Packet status codes
  localparam logic [3:0] PKT_GLOBAL_OUT_NAK = 4'h1;
  localparam logic [3:0] PKT_DATA_RECEIVED = 4'h2;
  localparam logic [3:0] PKT_TRANSFER_DONE = 4'h3;
  localparam logic [3:0] PKT_SETUP_DONE = 4'h4;
  localparam logic [3:0] PKT_TOGGLE_ERROR = 4'h5;
  localparam logic [3:0] PKT_SETUP_RECEIVED = 4'h6;
  localparam logic [3:0] PKT_CHANNEL_HALTED = 4'h7;
  // FIFO sizing fields
  localparam int FSIZE_DEPTH_LSB = 16;
  localparam logic [15:0] RX_DEPTH_RESET = 16'h0400;
  localparam logic [15:0] NP_DEPTH_RESET = 16'h0100;
  // Non-periodic status fields
  localparam int NPS_HEAD_LSB = 24;
  localparam int NPS_FREE_LSB = 16;
  localparam logic [7:0] NPQ_FREE_MAX = 8'h08;
  localparam logic [15:0] NPF_FREE_MAX = 16'h8000;
  // Two-wire control fields
  localparam int TW_BUSY_BIT = 31;
  localparam int TW_READ_BIT = 30;
  localparam int TW_ACK_BIT = 24;
  localparam int TW_ENABLE_BIT = 23;
  localparam logic [22:0] TW_WORD_RESET = 23'h00_0000;
  localparam logic TW_ACK_RESET = 1'b1;
  typedef enum logic {ROLE_DEVICE, ROLE_HOST} ocg_role_type;
endpackage : ocg_pkg

// *** ocg_rx_status_queue.sv ***
// Receive status entry queue, peeked and popped by software
`timescale 1ns/1ps
module ocg_rx_status_queue
  import ocg_pkg::*;
#(
  parameter int WIDTH = RXS_WIDTH,
  parameter int DEPTH = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic ready,
  output logic valid,
  output logic [WIDTH-1:0] head
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  ////////////////////////////////////////////////////////////////////////
  // Pointer and count update; full queue refuses pushes
  always_comb
  begin
    do_push = push && (cnt_q != (AW+1)'(DEPTH));
    do_pop = pop && (cnt_q != '0);
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (do_push)
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    if (do_pop)
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    if (do_push && !do_pop)
      cnt_d = cnt_q + 1'b1;
    else if (do_pop && !do_push)
      cnt_d = cnt_q - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (clk_en)
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; head is masked by valid
  always_ff @(posedge clk)
  begin
    if (clk_en && do_push)
      mem_q[wr_q] <= push_data;
  end

  assign ready = (cnt_q != (AW+1)'(DEPTH));
  assign valid = (cnt_q != '0);
  assign head = valid ? mem_q[rd_q] : '0;
endmodule : ocg_rx_status_queue

// *** ocg_two_wire_seq.sv ***
// Two-wire transfer sequencer behind the busy/done bit
`timescale 1ns/1ps
module ocg_two_wire_seq
  import ocg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic start,
  input wire logic master_enable,
  input wire logic link_done,
  input wire logic link_ack,
  output logic busy_q,
  output logic req_q,
  output logic ack_q,
  output logic done_q
);
  typedef enum logic [1:0] {TW_IDLE, TW_WAIT_ENABLE, TW_ISSUE, TW_WAIT_DONE} ocg_tw_state_type;
  ocg_tw_state_type state_q, state_d;
  logic busy_d, req_d, ack_d, done_d;

  ////////////////////////////////////////////////////////////////////////
  // Request waits for the enable, then one request pulse per start
  always_comb
  begin
    state_d = state_q;
    busy_d = busy_q;
    req_d = 1'b0;
    ack_d = ack_q;
    done_d = 1'b0;
    unique case (state_q)
      TW_IDLE:
        if (start)
        begin
          busy_d = 1'b1;
          state_d = master_enable ? TW_ISSUE : TW_WAIT_ENABLE;
        end
      TW_WAIT_ENABLE:
        if (master_enable)
          state_d = TW_ISSUE;
      TW_ISSUE:
      begin
        req_d = 1'b1;
        state_d = TW_WAIT_DONE;
      end
      TW_WAIT_DONE:
        if (link_done)
        begin
          busy_d = 1'b0;
          ack_d = link_ack;
          done_d = 1'b1;
          state_d = TW_IDLE;
        end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= TW_IDLE;
      busy_q <= 1'b0;
      req_q <= 1'b0;
      ack_q <= TW_ACK_RESET;
      done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      busy_q <= busy_d;
      req_q <= req_d;
      ack_q <= ack_d;
      done_q <= done_d;
    end
  end
endmodule : ocg_two_wire_seq
